// ==== core/pipeline_delay_pkg.sv ====
// pipeline_delay_pkg: constants shared by the delay line and its stages
// assumes: a single clock at 10 MHz, synchronous active-high reset
package pipeline_delay_pkg;

	// ======================================================
	// clock
	localparam int CLK_PERIOD_NS = 100;

	// ======================================================
	// storage structure
	localparam int LUT_DEPTH        = 32;
	localparam int LUT_ADDR_W       = 5;
	localparam int STAGE_MAX_DELAY  = 33;
	localparam int RAM_THRESHOLD    = 128;
	localparam int RAM_READ_LATENCY = 1;

	// ======================================================
	// implementation choices
	localparam int IMPL_AUTO = 0;
	localparam int IMPL_LUT  = 1;
	localparam int IMPL_ZERO = 2;
	localparam int IMPL_RAM  = 3;

	// ======================================================
	// helpers
	function automatic int stage_count(input int lat);
		return (lat + STAGE_MAX_DELAY - 1) / STAGE_MAX_DELAY;
	endfunction

	function automatic int stage_delay(input int lat, input int idx);
		if (idx < stage_count(lat) - 1)
			return STAGE_MAX_DELAY;
		return lat - STAGE_MAX_DELAY * (stage_count(lat) - 1);
	endfunction

	function automatic int pick_impl(input int req, input int lat);
		if (req != IMPL_AUTO)
			return req;
		if (lat > RAM_THRESHOLD)
			return IMPL_RAM;
		return IMPL_LUT;
	endfunction

endpackage

// ==== core/shift_lut_stage.sv ====
// shift_lut_stage: addressable shift store, tap picked by address
// assumes: caller registers the tap; contents are not reset
`timescale 1ns/1ns
`default_nettype none

module shift_lut_stage
	import pipeline_delay_pkg::*;
#(
	parameter int DATA_W = 16
) (
	// clock and control
	input  wire logic                  mclk,
	input  wire logic                  shift,
	// data
	input  wire logic [DATA_W-1:0]     d,
	input  wire logic [LUT_ADDR_W-1:0] addr,
	output logic      [DATA_W-1:0]     q
);

	logic [DATA_W-1:0] sr [LUT_DEPTH];

	// ======================================================
	// shift store
	always_ff @(posedge mclk) begin
		if (shift) begin
			sr[0] <= d;
			for (int i = 1; i < LUT_DEPTH; i++) begin
				sr[i] <= sr[i-1];
			end
		end
	end

	// tap delay is address plus one
	assign q = sr[addr];

	// ======================================================
	// checks
	a_stage_shift: assert property (@(posedge mclk)
		shift |=> sr[0] == $past(d))
		else $error("shift store missed a sample");
	a_stage_hold: assert property (@(posedge mclk)
		!shift |=> $stable(sr[0]))
		else $error("shift store moved while enable low");

endmodule
`default_nettype wire

// ==== core/ram_delay.sv ====
// ram_delay: dual-port memory delay with write and read counters
// assumes: DELAY above the read latency; caller gates stale output
`timescale 1ns/1ns
`default_nettype none

module ram_delay
	import pipeline_delay_pkg::*;
#(
	parameter int DATA_W = 16,
	parameter int DELAY  = 200
) (
	// clock and control
	input  wire logic              mclk,
	input  wire logic              rst,
	input  wire logic              shift,
	// data
	input  wire logic [DATA_W-1:0] d,
	output logic      [DATA_W-1:0] q
);

	localparam int AW     = $clog2(DELAY + 1);
	localparam int OFFSET = DELAY - RAM_READ_LATENCY;
	localparam logic [AW-1:0] RD_START = AW'(-OFFSET);
	localparam logic [AW-1:0] GAP      = AW'(OFFSET);

	logic [DATA_W-1:0] mem [2**AW];
	logic [AW-1:0]     wptr;
	logic [AW-1:0]     rptr;

	// ======================================================
	// address counters, gap fixed at delay minus read latency
	always_ff @(posedge mclk) begin
		if (rst) begin
			wptr <= '0;
			rptr <= RD_START;
		end else if (shift) begin
			wptr <= wptr + 1'b1;
			rptr <= rptr + 1'b1;
		end
	end

	// ======================================================
	// memory ports
	always_ff @(posedge mclk) begin
		if (shift) begin
			mem[wptr] <= d;
		end
	end

	always_ff @(posedge mclk) begin
		if (shift) begin
			q <= mem[rptr];
		end
	end

	// ======================================================
	// checks
	a_ptr_gap: assert property (@(posedge mclk) disable iff (rst)
		AW'(wptr - rptr) == GAP)
		else $error("address counter gap lost");
	a_ptr_hold: assert property (@(posedge mclk) disable iff (rst)
		!shift |=> $stable(wptr) && $stable(rptr))
		else $error("address counters moved while enable low");

endmodule
`default_nettype wire

// ==== core/pipeline_delay_line.sv ====
// pipeline_delay_line: fixed-latency delay for datapath matching
// assumes: d_in and en come from logic on mclk; rst is synchronous
// assumes: the memory form is only picked for a latency of at least 3
//
// Summary of operation
// - default form: lookup shift stage of L-1 cycles, then one flip-flop
// - latency above 33 cascades several shift-stage and flip-flop pairs
// - shift stage delay equals its tap address plus one
// - one shift stage plus flip-flop gives at most 33 cycles
// - optional leading register adds one cycle and ends input paths at a flop
// - long delays above 128 use dual-port memory with address counters
// - memory delay set by counter gap plus read latency; counters binary
// - zero-on-reset form uses a chain of L-1 resettable registers, then the output flop
// - after reset the output is forced zero until old contents flush out
// - no initial contents; only the resettable flops start from zero
// - each sample appears unchanged exactly L enabled cycles later, L+1 with the leading register
// - reset clears every flop except the memory read register and read counter (preset), overriding enable; shift stage and memory contents are not reset
// - enable low holds every stage; shifting resumes only on enable, not on reset
// - zero latency allowed only without enable; becomes a plain wire
`timescale 1ns/1ns
`default_nettype none

module pipeline_delay_line
	import pipeline_delay_pkg::*;
#(
	parameter int DATA_W     = 16,
	parameter int LATENCY    = 4,
	parameter int IMPL       = IMPL_AUTO,
	parameter bit HAS_ENABLE = 1'b1,
	parameter bit INPUT_REG  = 1'b0
) (
	// clock and reset
	input  wire logic              mclk,
	input  wire logic              rst,
	// control
	input  wire logic              en,
	// data
	input  wire logic [DATA_W-1:0] d_in,
	output logic      [DATA_W-1:0] d_out
);

	localparam int MODE     = pick_impl(IMPL, LATENCY);
	localparam int CORE_LEN = (LATENCY > 0) ? LATENCY - 1 : 0;
	localparam int TOTAL    = LATENCY + int'(INPUT_REG);
	localparam int CW       = $clog2(TOTAL + 2) + 1;

	logic              shift;
	logic [DATA_W-1:0] src;

	// ======================================================
	// enable: tied on when no enable is configured
	assign shift = HAS_ENABLE ? en : 1'b1;

	// ======================================================
	// configuration checks
	a_zero_no_en: assert property (@(posedge mclk)
		!(LATENCY == 0 && HAS_ENABLE))
		else $error("zero latency with enable configured");

	a_mode_long: assert property (@(posedge mclk)
		(IMPL == IMPL_AUTO && LATENCY > RAM_THRESHOLD) |-> MODE == IMPL_RAM)
		else $error("long delay not placed in memory");

	// ======================================================
	// optional leading register
	if (INPUT_REG) begin : g_in_reg
		logic [DATA_W-1:0] in_q;
		always_ff @(posedge mclk) begin
			if (rst) begin
				in_q <= '0;
			end else if (shift) begin
				in_q <= d_in;
			end
		end
		assign src = in_q;

		a_in_take: assert property (@(posedge mclk) disable iff (rst)
			shift |=> in_q == $past(d_in))
			else $error("input register missed a sample");

		a_in_clear: assert property (@(posedge mclk)
			rst |=> in_q == '0)
			else $error("input register not cleared by reset");

		a_in_hold: assert property (@(posedge mclk) disable iff (rst)
			!shift |=> $stable(in_q))
			else $error("input register moved while enable low");
	end else begin : g_no_in_reg
		assign src = d_in;
	end

	// ======================================================
	// zero latency: a direct connection
	if (LATENCY == 0) begin : g_wire
		assign d_out = src;
	end else begin : g_line
		logic [DATA_W-1:0] core_q;
		logic              flushed;

		// ------------------------------------------------------
		// storage core, delay LATENCY-1 ahead of the output flop
		if (CORE_LEN == 0) begin : g_core_none
			assign core_q = src;
			assign flushed = 1'b1;
		end else if (MODE == IMPL_ZERO) begin : g_core_zero
			logic [DATA_W-1:0] chain [CORE_LEN];
			always_ff @(posedge mclk) begin
				if (rst) begin
					for (int i = 0; i < CORE_LEN; i++) begin
						chain[i] <= '0;
					end
				end else if (shift) begin
					chain[0] <= src;
					for (int i = 1; i < CORE_LEN; i++) begin
						chain[i] <= chain[i-1];
					end
				end
			end
			assign core_q = chain[CORE_LEN-1];
			assign flushed = 1'b1;

			a_chain_clear: assert property (@(posedge mclk)
				rst |=> chain[CORE_LEN-1] == '0)
				else $error("register chain not cleared by reset");

			a_chain_shift: assert property (@(posedge mclk) disable iff (rst)
				shift |=> chain[0] == $past(src))
				else $error("register chain missed a sample");

			a_chain_hold: assert property (@(posedge mclk) disable iff (rst)
				!shift |=> $stable(chain[0]))
				else $error("register chain moved while enable low");
		end else begin : g_core_stale
			logic [CW-1:0] fill;

			// count enabled cycles since reset until stale data is gone
			always_ff @(posedge mclk) begin
				if (rst) begin
					fill <= '0;
				end else if (shift && fill != CW'(CORE_LEN)) begin
					fill <= fill + 1'b1;
				end
			end
			assign flushed = (fill == CW'(CORE_LEN));

			a_fill_cap: assert property (@(posedge mclk) disable iff (rst)
				fill <= CW'(CORE_LEN))
				else $error("flush counter ran past the core length");

			a_flush_start: assert property (@(posedge mclk)
				rst |=> !flushed)
				else $error("flush not restarted by reset");

			a_fill_hold: assert property (@(posedge mclk) disable iff (rst)
				!shift |=> $stable(fill))
				else $error("flush counter moved while enable low");

			if (MODE == IMPL_RAM) begin : g_core_ram
				ram_delay #(
					.DATA_W (DATA_W),
					.DELAY  (CORE_LEN)
				) u_ram (
					.mclk  (mclk),
					.rst   (rst),
					.shift (shift),
					.d     (src),
					.q     (core_q)
				);
			end else begin : g_core_lut
				localparam int NST = stage_count(LATENCY);
				logic [DATA_W-1:0] link [NST];
				assign link[0] = src;

				for (genvar s = 0; s < NST; s++) begin : g_stage
					localparam int SEG = stage_delay(LATENCY, s);
					logic [DATA_W-1:0] tap;

					// each pair: lookup part SEG-1, flop one
					if (SEG == 1) begin : g_flop_only
						assign tap = link[s];
					end else begin : g_lut
						localparam logic [LUT_ADDR_W-1:0] ADDR =
							LUT_ADDR_W'(SEG - 2);
						shift_lut_stage #(
							.DATA_W (DATA_W)
						) u_lut (
							.mclk  (mclk),
							.shift (shift),
							.d     (link[s]),
							.addr  (ADDR),
							.q     (tap)
						);
						a_seg_bound: assert property (@(posedge mclk)
							SEG <= STAGE_MAX_DELAY)
							else $error("shift stage longer than one pair allows");
					end

					if (s < NST - 1) begin : g_pair_flop
						logic [DATA_W-1:0] pair_q;

						always_ff @(posedge mclk) begin
							if (rst) begin
								pair_q <= '0;
							end else if (shift) begin
								pair_q <= tap;
							end
						end
						assign link[s+1] = pair_q;

						a_pair_clear: assert property (@(posedge mclk)
							rst |=> pair_q == '0)
							else $error("pair flop not cleared by reset");

						a_pair_hold: assert property (@(posedge mclk) disable iff (rst)
							!shift |=> $stable(pair_q))
							else $error("pair flop moved while enable low");
					end else begin : g_last
						assign core_q = tap;
					end
				end
			end
		end

		// ------------------------------------------------------
		// output flop, zero while stale data flushes
		always_ff @(posedge mclk) begin
			if (rst) begin
				d_out <= '0;
			end else if (shift) begin
				d_out <= flushed ? core_q : '0;
			end
		end

		// ------------------------------------------------------
		// checks
		logic [CW-1:0] run;
		always_ff @(posedge mclk) begin
			if (rst || !shift) begin
				run <= '0;
			end else if (run <= CW'(TOTAL)) begin
				run <= run + 1'b1;
			end
		end

		// ======================================================
		// latency checks
		a_latency_exact: assert property (@(posedge mclk) disable iff (rst)
			run > CW'(TOTAL) |-> d_out == $past(d_in, TOTAL))
			else $error("output differs from input delayed by latency");

		a_out_follows: assert property (@(posedge mclk) disable iff (rst)
			shift && flushed |=> d_out == $past(core_q))
			else $error("output flop missed the core tap");

		a_lanes_same: assert property (@(posedge mclk) disable iff (rst)
			run > CW'(TOTAL) |-> d_out[0] == $past(d_in[0], TOTAL)
				&& d_out[DATA_W-1] == $past(d_in[DATA_W-1], TOTAL))
			else $error("lanes delayed unequally");

		// ======================================================
		// reset and flush checks
		a_reset_wins: assert property (@(posedge mclk)
			rst |=> d_out == '0)
			else $error("output not cleared by reset");

		a_flush_zero: assert property (@(posedge mclk) disable iff (rst)
			!flushed |=> d_out == '0)
			else $error("stale data reached the output");

		a_flush_ends: assert property (@(posedge mclk) disable iff (rst)
			$rose(run == CW'(TOTAL)) |-> flushed)
			else $error("flush not done after a full run");

		// ======================================================
		// enable checks
		a_hold_disabled: assert property (@(posedge mclk) disable iff (rst)
			!shift ##1 !rst |-> $stable(d_out))
			else $error("output moved while enable low");

		// ======================================================
		// cover points
		c_full_run: cover property (@(posedge mclk) disable iff (rst)
			run > CW'(TOTAL));
		c_stall: cover property (@(posedge mclk) disable iff (rst)
			shift ##1 !shift ##1 shift);
		c_reset_en: cover property (@(posedge mclk)
			rst && shift ##1 !rst);
		c_flushed: cover property (@(posedge mclk) disable iff (rst)
			$rose(flushed));
		c_reset_again: cover property (@(posedge mclk)
			!rst ##1 rst);
	end

endmodule
`default_nettype wire

// ==== testbench/sample_source.sv ====
// sample_source: upstream datapath logic feeding the delay line
// assumes: samples change on the falling edge of mclk, one new value per cycle
`timescale 1ns/1ns
`default_nettype none

module sample_source #(
	parameter int W = 16
) (
	// clock
	input  wire logic         mclk,
	// data
	output logic      [W-1:0] data
);
	// ======================================================
	// rotating pattern so every lane toggles and no value repeats soon
	initial data = W'(16'h0001);
	always @(negedge mclk) begin
		data <= {data[W-2:0], ~data[W-1]} ^ W'(16'h2d41);
	end
endmodule

`default_nettype wire

// ==== testbench/tb_top.sv ====
// tb_top: self-checking bench for pipeline_delay_line in several forms
// assumes: sample_source upstream; rst and en driven on falling edges
`timescale 1ns/1ns
`default_nettype none

module tb_top;
	import pipeline_delay_pkg::*;

	// ======================================================
	// forms under test: lookup, cascade, zero-reset, memory, input register, automatic pick
	localparam int     DW             = 16;
	localparam int     N_DUT          = 6;
	localparam int     LATS[N_DUT]    = '{4, 40, 5, 6, 3, 7};
	localparam int     IMPLS[N_DUT]   = '{IMPL_LUT, IMPL_LUT, IMPL_ZERO,
	                                      IMPL_RAM, IMPL_LUT, IMPL_AUTO};
	localparam bit     INREG[N_DUT]   = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0};

	logic              mclk = 1'b0;
	logic              rst  = 1'b1;
	logic              en   = 1'b1;
	logic [15:0]       d_in;
	logic [15:0]       outs [N_DUT];
	logic [15:0]       o_wire;
	logic [15:0]       hist [0:4095];
	int                n = 0;
	int                error_cnt = 0;
	int                check_count = 0;

	always #50 mclk = ~mclk;

	sample_source #(.W(DW)) src (.mclk(mclk), .data(d_in));

	// ======================================================
	// design instances
	for (genvar gi = 0; gi < N_DUT; gi++) begin : g_dut
		pipeline_delay_line #(.DATA_W(DW), .LATENCY(LATS[gi]), .IMPL(IMPLS[gi]),
			.HAS_ENABLE(1'b1), .INPUT_REG(INREG[gi])) dut (
			.mclk(mclk), .rst(rst), .en(en), .d_in(d_in), .d_out(outs[gi]));
	end

	pipeline_delay_line #(.DATA_W(DW), .LATENCY(0), .HAS_ENABLE(1'b0)) dut (
		.mclk(mclk), .rst(rst), .en(en), .d_in(d_in), .d_out(o_wire));

	// ======================================================
	// checking helpers
	task automatic chk(input logic [15:0] seen, input logic [15:0] want);
		check_count++;
		if (seen !== want) begin
			error_cnt++;
			$display("[FAIL] %0t ns: output %h expected %h", $time, seen, want);
		end
	endtask

	function automatic logic [15:0] expv(input int tot);
		if (n >= tot)
			return hist[n - tot + 1];
		return 16'h0000;
	endfunction

	// one cycle: judge settled outputs, drive inputs, then update the model
	task automatic cyc(input logic e, input logic r);
		@(negedge mclk);
		for (int k = 0; k < N_DUT; k++) begin
			chk(outs[k], expv(LATS[k] + int'(INREG[k])));
		end
		en  = e;
		rst = r;
		#1 chk(o_wire, d_in);
		@(posedge mclk);
		if (r)
			n = 0;
		else if (e) begin
			n++;
			hist[n] = d_in;
		end
	endtask

	// ======================================================
	// scenarios
	task automatic sc_reset();
		repeat (2) @(posedge mclk);
		repeat (18) cyc(1'b1, 1'b1);
	endtask

	task automatic sc_stream();
		repeat (90) cyc(1'b1, 1'b0);
	endtask

	task automatic sc_stall();
		for (int i = 0; i < 70; i++) begin
			cyc((i % 7) < 4 && !(i >= 30 && i < 36), 1'b0);
		end
	endtask

	task automatic sc_reset_mid();
		repeat (2) cyc(1'b0, 1'b1);
		repeat (60) cyc(1'b1, 1'b0);
	endtask

	// ======================================================
	// verdict and watchdog
	task automatic give_verdict();
		if (error_cnt == 0 && check_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	initial begin
		#(400 * 100 * 3);
		error_cnt++;
		give_verdict();
	end

	initial begin
		sc_reset();
		sc_stream();
		sc_stall();
		sc_reset_mid();
		give_verdict();
	end
endmodule

`default_nettype wire
